/* File: sim/iopcd_user_hw.sv */
/*
  Model of the user's I/O and diagnosis hardware behind ports A to E.
  Assumes the bench sets the level that the user hardware applies to each pin.
*/
`timescale 1ns/1ps

module iopcd_user_hw (
  input wire logic [7:0] port_a_o,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_o,
  input wire logic [7:0] port_b_oe,
  input wire logic [7:0] port_c_o,
  input wire logic [7:0] port_c_oe,
  input wire logic [7:0] port_d_o,
  input wire logic [7:0] port_d_oe,
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  input wire logic [7:0] ext_c,
  input wire logic [7:0] ext_d,
  input wire logic [7:0] ext_e,
  output logic [7:0] port_a_i,
  output logic [7:0] port_b_i,
  output logic [7:0] port_c_i,
  output logic [7:0] port_d_i,
  output logic [7:0] port_e_i
);
  // A pin driven by the device shows its level, so the user side never fights it.
  assign port_a_i = (port_a_oe & port_a_o) | (~port_a_oe & ext_a);
  assign port_b_i = (port_b_oe & port_b_o) | (~port_b_oe & ext_b);
  assign port_c_i = (port_c_oe & port_c_o) | (~port_c_oe & ext_c);
  assign port_d_i = (port_d_oe & port_d_o) | (~port_d_oe & ext_d);
  // Group lines idle high through pull-ups; a low level is a pending error.
  assign port_e_i = ext_e;
endmodule : iopcd_user_hw

/* File: sim/testbench.sv */
/*
  Self-checking bench for the port configuration and diagnosis block.
  Assumes the user hardware model beside the design; the configuration
  code is only changed while reset is held, as on a power cycle.
*/
`timescale 1ns/1ps
`include "iopcd_cfg.svh"

module testbench;
  import iopcd_pkg::*;
  logic clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic eng_cons_req, consistency_strobe, diag_error_out, change_valid, change_ready;
  logic [4:0] port_config_pins;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [23:0] change_data;
  logic [7:0] port_a_i, port_b_i, port_c_i, port_d_i, port_e_i;
  logic [7:0] port_a_o, port_b_o, port_c_o, port_d_o;
  logic [7:0] port_a_oe, port_b_oe, port_c_oe, port_d_oe;
  logic [7:0] eng_out_a, eng_out_b, eng_out_c, eng_out_d;
  logic [7:0] eng_in_a, eng_in_b, eng_in_c, eng_in_d;
  logic [7:0] ext_a, ext_b, ext_c, ext_d, ext_e;
  int err_total = 0;
  int comparisons = 0;
  // Codes from every group of the map: plain, all unused, overall, extended.
  logic [4:0] cfg_tab [7] = '{5'h00, 5'h07, 5'h0B, 5'h15, 5'h11, 5'h12, 5'h1B};
  logic [7:0] dir_tab [7] = '{8'hFC, 8'h01, 8'hFF, 8'hF0, 8'hA0, 8'hED, 8'hA5};
  logic [1:0] flg_tab [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3};

  iopcd_top iopcd_top_inst (.clk_sys, .reset, .port_config_pins, .wb_adr_i, .wb_dat_i,
    .wb_dat_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_ack_o, .port_a_i, .port_a_o,
    .port_a_oe, .port_b_i, .port_b_o, .port_b_oe, .port_c_i, .port_c_o, .port_c_oe,
    .port_d_i, .port_d_o, .port_d_oe, .port_e_i, .eng_out_a, .eng_out_b, .eng_out_c,
    .eng_out_d, .eng_in_a, .eng_in_b, .eng_in_c, .eng_in_d, .eng_cons_req,
    .consistency_strobe, .diag_error_out, .change_valid, .change_ready, .change_data);

  iopcd_user_hw iopcd_user_hw_inst (.port_a_o, .port_a_oe, .port_b_o, .port_b_oe, .port_c_o,
    .port_c_oe, .port_d_o, .port_d_oe, .ext_a, .ext_b, .ext_c, .ext_d, .ext_e, .port_a_i,
    .port_b_i, .port_c_i, .port_d_i, .port_e_i);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // Output enables are all ones for OUT and unused ports, whose codes are odd.
  function automatic logic [31:0] oe_of(input logic [7:0] dr);
    logic [31:0] r;
    for (int k = 0; k < 4; k++) begin
      r[8*k +: 8] = {8{dr[2*k]}};
    end
    return r;
  endfunction : oe_of

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         input logic [3:0] sel);
    int n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer

  task automatic power_up(input logic [4:0] code);
    @(posedge clk_sys);
    reset <= 1'b1;
    port_config_pins <= code;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : power_up

  task automatic diag_step(input logic [7:0] e, c, d, input logic err, chg,
                           input logic [23:0] data);
    ext_e <= e;
    ext_c <= c;
    ext_d <= d;
    repeat (6) @(posedge clk_sys);
    check(diag_error_out, err);
    check(change_valid, chg);
    check(change_data, data);
    if (chg) begin
      change_ready <= 1'b1;
      @(posedge clk_sys);
      change_ready <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check(change_valid, 1'b0);
      wb_xfer(1'b0, `IOPCD_LAST_OFS, 32'h0, 4'hF);
      check(rd, data);
    end
  endtask : diag_step

  initial begin
    reset = 1'b1;
    port_config_pins = 5'h00;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    {eng_out_a, eng_out_b, eng_out_c, eng_out_d, eng_cons_req, change_ready} = '0;
    {ext_a, ext_b, ext_c, ext_d, ext_e} = '1;
    foreach (cfg_tab[i]) begin
      power_up(cfg_tab[i]);
      wb_xfer(1'b0, `IOPCD_STAT_OFS, 32'h0, 4'hF);
      check(rd & 32'h00FF01FF, {8'h00, dir_tab[i], 9'h000, flg_tab[i], cfg_tab[i]});
      check({port_d_oe, port_c_oe, port_b_oe, port_a_oe}, oe_of(dir_tab[i]));
      eng_cons_req <= 1'b1;
      @(posedge clk_sys);
      eng_cons_req <= 1'b0;
      check(consistency_strobe, 1'b0);
      @(posedge clk_sys);
      check(consistency_strobe, flg_tab[i][0]);
      @(posedge clk_sys);
      check(consistency_strobe, 1'b0);
    end
    // Status is read-only and holes in the map read as zero.
    wb_xfer(1'b1, `IOPCD_STAT_OFS, 32'hFFFFFFFF, 4'hF);
    wb_xfer(1'b0, `IOPCD_STAT_OFS, 32'h0, 4'hF);
    check(rd & 32'h00FF007F, 32'h00A5007B);
    wb_xfer(1'b0, 8'h40, 32'h0, 4'hF);
    check(rd, 32'h0);
    power_up(5'h07);
    eng_out_a <= 8'h5A;
    eng_out_b <= 8'h33;
    eng_out_c <= 8'hAA;
    eng_out_d <= 8'h55;
    ext_b <= 8'hC3;
    ext_c <= 8'h96;
    ext_d <= 8'h3C;
    repeat (5) @(posedge clk_sys);
    check(port_a_o, 8'h5A);
    check(port_b_o, 8'h00);
    check(port_c_o, 8'h00);
    check(port_d_o, 8'h00);
    check(eng_in_b, 8'hC3);
    check(eng_in_c, 8'h96);
    check(eng_in_d, 8'h3C);
    check(eng_in_a, 8'h00);
    // Lows on C and D count for nothing while they are plain inputs.
    diag_step(8'hFE, 8'h00, 8'h00, 1'b1, 1'b1, 24'h000001);
    diag_step(8'hFF, 8'hFF, 8'hFF, 1'b0, 1'b1, 24'h000000);
    power_up(5'h11);
    wb_xfer(1'b0, `IOPCD_PRM_OFS, 32'h0, 4'hF);
    check(rd, 32'h0);
    diag_step(8'hFB, 8'hFF, 8'hFF, 1'b1, 1'b1, 24'h000004);
    diag_step(8'hFF, 8'hFF, 8'hFF, 1'b0, 1'b1, 24'h000000);
    wb_xfer(1'b1, `IOPCD_PRM_OFS, 32'h00000001, 4'h1);
    diag_step(8'hFD, 8'hFF, 8'hFF, 1'b0, 1'b0, 24'h000000);
    diag_step(8'hFD, 8'hFE, 8'hFF, 1'b1, 1'b1, 24'h000102);
    diag_step(8'hDF, 8'hFF, 8'hFF, 1'b1, 1'b1, 24'h000020);
    diag_step(8'hFF, 8'hFF, 8'hFF, 1'b0, 1'b1, 24'h000000);
    wb_xfer(1'b1, `IOPCD_PRM_OFS, 32'h00000100, 4'h3);
    diag_step(8'hFF, 8'hFE, 8'hFF, 1'b0, 1'b0, 24'h000000);
    diag_step(8'hFF, 8'hFE, 8'h7F, 1'b1, 1'b1, 24'h800000);
    diag_step(8'hFF, 8'hFF, 8'hFF, 1'b0, 1'b1, 24'h000000);
    wb_xfer(1'b0, `IOPCD_PRM_OFS, 32'h0, 4'hF);
    check(rd, 32'h00000100);
    power_up(5'h11);
    wb_xfer(1'b0, `IOPCD_PRM_OFS, 32'h0, 4'hF);
    check(rd, 32'h0);
    conclude();
  end

  // The whole sequence needs well under 2000 cycles.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    conclude();
  end
endmodule : testbench

/* File: verilog/iopcd_cfg.svh */
/*
  Constants for the I/O port configuration and diagnosis block: register
  offsets, field positions, reset values and widths.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef IOPCD_CFG_SVH
`define IOPCD_CFG_SVH

`define IOPCD_PW 8
`define IOPCD_NPORT 4
`define IOPCD_CW 5
`define IOPCD_DW 24
`define IOPCD_AW 8
`define IOPCD_BW 32

`define IOPCD_PRM_OFS 8'h00
`define IOPCD_STAT_OFS 8'h04
`define IOPCD_NOW_OFS 8'h08
`define IOPCD_LAST_OFS 8'h0C

`define IOPCD_PRM_QUAL_BIT 0
`define IOPCD_PRM_MC_LSB 8
`define IOPCD_PRM_MD_LSB 16
`define IOPCD_SEL_QUAL 0
`define IOPCD_SEL_MC 1
`define IOPCD_SEL_MD 2

`define IOPCD_ST_CODE_LSB 0
`define IOPCD_ST_OVERALL_BIT 5
`define IOPCD_ST_EXT_BIT 6
`define IOPCD_ST_ERR_BIT 7
`define IOPCD_ST_CHG_BIT 8
`define IOPCD_ST_DIR_LSB 16

`define IOPCD_DV_E_LSB 0
`define IOPCD_DV_C_LSB 8
`define IOPCD_DV_D_LSB 16
`define IOPCD_E_HALF 4

`define IOPCD_PORT_C 2
`define IOPCD_PORT_D 3

`define IOPCD_CFG_RST 5'h00
`define IOPCD_PIN_RST 8'hFF
`define IOPCD_IDLE_PORT 8'h00
`define IOPCD_ALL_ON 8'hFF

`endif

/* File: verilog/iopcd_pkg.sv */
/*
  Types for the I/O port configuration and diagnosis block.
  Assumes the constants header is on the include path.
*/
`include "iopcd_cfg.svh"

package iopcd_pkg;

  typedef enum logic [1:0] {
    DIR_IN = 2'h0,
    DIR_OUT = 2'h1,
    DIR_DG = 2'h2,
    DIR_UN = 2'h3
  } iopcd_dir_e;

  typedef struct packed {
    logic overall;
    logic ext_diag;
    iopcd_dir_e [`IOPCD_NPORT-1:0] dir;
  } iopcd_map_s;

  typedef struct packed {
    logic qual_flag;
    logic [`IOPCD_PW-1:0] mask_c;
    logic [`IOPCD_PW-1:0] mask_d;
    logic [`IOPCD_DW-1:0] cur_diag;
    logic [`IOPCD_DW-1:0] last_diag;
    logic diag_err;
    logic cons_strobe;
    logic ack;
    logic [`IOPCD_BW-1:0] rdata;
    logic [`IOPCD_NPORT-1:0][`IOPCD_PW-1:0] in_data;
    logic [`IOPCD_NPORT-1:0][`IOPCD_PW-1:0] out_data;
  } iopcd_state_s;

endpackage : iopcd_pkg

/* File: verilog/iopcd_sync2.sv */
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes pins that are asynchronous to clk_sys and a synchronous reset.
*/
`timescale 1ns/1ps

module iopcd_sync2 #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } iopcd_sync_s;

  iopcd_sync_s s_reg;
  iopcd_sync_s s_next;

  // The first stage feeds only the second stage.
  always_comb begin
    s_next.meta = pin_i;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg <= {RST_VAL, RST_VAL};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_o = s_reg.sync;

endmodule : iopcd_sync2

/* File: verilog/iopcd_top.sv */
/*
  Static port configuration and diagnosis evaluation for four 8-bit I/O
  ports and one group diagnosis port, with a classic Wishbone register
  slave and a change-report handshake toward the protocol engine.
  Assumes clk_sys at 250 MHz, a synchronous active-high reset, and a
  protocol engine on the same clock driving the data and strobe inputs.
*/
`timescale 1ns/1ps
`include "iopcd_cfg.svh"

module iopcd_top
  import iopcd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [`IOPCD_CW-1:0] port_config_pins,
  input wire logic [`IOPCD_AW-1:0] wb_adr_i,
  input wire logic [`IOPCD_BW-1:0] wb_dat_i,
  output logic [`IOPCD_BW-1:0] wb_dat_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  input wire logic [`IOPCD_PW-1:0] port_a_i,
  output logic [`IOPCD_PW-1:0] port_a_o,
  output logic [`IOPCD_PW-1:0] port_a_oe,
  input wire logic [`IOPCD_PW-1:0] port_b_i,
  output logic [`IOPCD_PW-1:0] port_b_o,
  output logic [`IOPCD_PW-1:0] port_b_oe,
  input wire logic [`IOPCD_PW-1:0] port_c_i,
  output logic [`IOPCD_PW-1:0] port_c_o,
  output logic [`IOPCD_PW-1:0] port_c_oe,
  input wire logic [`IOPCD_PW-1:0] port_d_i,
  output logic [`IOPCD_PW-1:0] port_d_o,
  output logic [`IOPCD_PW-1:0] port_d_oe,
  input wire logic [`IOPCD_PW-1:0] port_e_i,
  input wire logic [`IOPCD_PW-1:0] eng_out_a,
  input wire logic [`IOPCD_PW-1:0] eng_out_b,
  input wire logic [`IOPCD_PW-1:0] eng_out_c,
  input wire logic [`IOPCD_PW-1:0] eng_out_d,
  output logic [`IOPCD_PW-1:0] eng_in_a,
  output logic [`IOPCD_PW-1:0] eng_in_b,
  output logic [`IOPCD_PW-1:0] eng_in_c,
  output logic [`IOPCD_PW-1:0] eng_in_d,
  input wire logic eng_cons_req,
  output logic consistency_strobe,
  output logic diag_error_out,
  output logic change_valid,
  input wire logic change_ready,
  output logic [`IOPCD_DW-1:0] change_data
);

  iopcd_state_s s_reg;
  iopcd_state_s s_next;
  iopcd_map_s cfg_map;
  logic [`IOPCD_CW-1:0] cfg_code;
  logic [`IOPCD_NPORT-1:0][`IOPCD_PW-1:0] pin_sync;
  logic [`IOPCD_NPORT-1:0][`IOPCD_PW-1:0] eng_out;
  logic [`IOPCD_NPORT-1:0][`IOPCD_PW-1:0] oe_vec;
  logic [`IOPCD_PW-1:0] e_sync;
  logic [`IOPCD_PW-1:0] err_c;
  logic [`IOPCD_PW-1:0] err_d;
  logic [`IOPCD_PW-1:0] err_e;
  logic chan_err;
  logic [`IOPCD_DW-1:0] diag_vec;
  logic wb_req;
  logic hand_over;

  function automatic iopcd_map_s mk(input iopcd_dir_e a, input iopcd_dir_e b,
                                    input iopcd_dir_e c, input iopcd_dir_e d,
                                    input logic o);
    iopcd_map_s m;
    m.dir[0] = a;
    m.dir[1] = b;
    m.dir[2] = c;
    m.dir[3] = d;
    m.overall = o;
    m.ext_diag = (c == DIR_DG);
    return m;
  endfunction : mk

  // Codes outside the table leave every port unused, which is the safe state.
  function automatic iopcd_map_s decode(input logic [`IOPCD_CW-1:0] code);
    iopcd_map_s m;
    case (code)
      5'h00: m = mk(DIR_IN, DIR_UN, DIR_UN, DIR_UN, 1'h0);
      5'h01: m = mk(DIR_IN, DIR_IN, DIR_UN, DIR_UN, 1'h0);
      5'h02: m = mk(DIR_IN, DIR_IN, DIR_IN, DIR_UN, 1'h0);
      5'h03: m = mk(DIR_IN, DIR_IN, DIR_IN, DIR_IN, 1'h0);
      5'h04: m = mk(DIR_OUT, DIR_UN, DIR_UN, DIR_UN, 1'h0);
      5'h05: m = mk(DIR_OUT, DIR_IN, DIR_UN, DIR_UN, 1'h0);
      5'h06: m = mk(DIR_OUT, DIR_IN, DIR_IN, DIR_UN, 1'h0);
      5'h07: m = mk(DIR_OUT, DIR_IN, DIR_IN, DIR_IN, 1'h0);
      5'h08: m = mk(DIR_OUT, DIR_OUT, DIR_UN, DIR_UN, 1'h0);
      5'h09: m = mk(DIR_OUT, DIR_OUT, DIR_IN, DIR_UN, 1'h0);
      5'h0A: m = mk(DIR_OUT, DIR_OUT, DIR_IN, DIR_IN, 1'h0);
      5'h0C: m = mk(DIR_OUT, DIR_OUT, DIR_OUT, DIR_UN, 1'h0);
      5'h0D: m = mk(DIR_OUT, DIR_OUT, DIR_OUT, DIR_IN, 1'h0);
      5'h0F: m = mk(DIR_OUT, DIR_OUT, DIR_OUT, DIR_OUT, 1'h0);
      5'h10: m = mk(DIR_IN, DIR_UN, DIR_DG, DIR_UN, 1'h0);
      5'h11: m = mk(DIR_IN, DIR_IN, DIR_DG, DIR_DG, 1'h0);
      5'h12: m = mk(DIR_OUT, DIR_UN, DIR_DG, DIR_UN, 1'h0);
      5'h13: m = mk(DIR_OUT, DIR_OUT, DIR_DG, DIR_DG, 1'h0);
      5'h14: m = mk(DIR_OUT, DIR_IN, DIR_DG, DIR_DG, 1'h0);
      5'h15: m = mk(DIR_IN, DIR_IN, DIR_UN, DIR_UN, 1'h1);
      5'h16: m = mk(DIR_IN, DIR_IN, DIR_IN, DIR_IN, 1'h1);
      5'h17: m = mk(DIR_OUT, DIR_OUT, DIR_UN, DIR_UN, 1'h1);
      5'h18: m = mk(DIR_OUT, DIR_OUT, DIR_OUT, DIR_OUT, 1'h1);
      5'h19: m = mk(DIR_OUT, DIR_OUT, DIR_IN, DIR_IN, 1'h1);
      5'h1A: m = mk(DIR_IN, DIR_IN, DIR_DG, DIR_DG, 1'h1);
      5'h1B: m = mk(DIR_OUT, DIR_OUT, DIR_DG, DIR_DG, 1'h1);
      5'h1C: m = mk(DIR_IN, DIR_IN, DIR_IN, DIR_UN, 1'h1);
      5'h1D: m = mk(DIR_OUT, DIR_OUT, DIR_OUT, DIR_UN, 1'h1);
      5'h1E: m = mk(DIR_OUT, DIR_OUT, DIR_OUT, DIR_IN, 1'h1);
      5'h1F: m = mk(DIR_OUT, DIR_IN, DIR_IN, DIR_IN, 1'h1);
      default: m = mk(DIR_UN, DIR_UN, DIR_UN, DIR_UN, 1'h0);
    endcase
    return m;
  endfunction : decode

  // The configuration pins are static, but they are still synchronised so
  // that a slow power-up ramp cannot upset the decode.
  iopcd_sync2 #(
    .W(`IOPCD_CW),
    .RST_VAL(`IOPCD_CFG_RST)
  ) u_sync_cfg (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_i(port_config_pins),
    .sync_o(cfg_code)
  );

  iopcd_sync2 #(
    .W(`IOPCD_NPORT * `IOPCD_PW),
    .RST_VAL({`IOPCD_NPORT{`IOPCD_PIN_RST}})
  ) u_sync_port (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_i({port_d_i, port_c_i, port_b_i, port_a_i}),
    .sync_o(pin_sync)
  );

  iopcd_sync2 #(
    .W(`IOPCD_PW),
    .RST_VAL(`IOPCD_PIN_RST)
  ) u_sync_e (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_i(port_e_i),
    .sync_o(e_sync)
  );

  assign cfg_map = decode(cfg_code);
  assign eng_out = {eng_out_d, eng_out_c, eng_out_b, eng_out_a};

  // Diagnosis evaluation on active-low, synchronised pins.
  always_comb begin
    err_c = '0;
    err_d = '0;
    if (cfg_map.dir[`IOPCD_PORT_C] == DIR_DG) begin
      err_c = ~pin_sync[`IOPCD_PORT_C] & ~s_reg.mask_c;
    end
    if (cfg_map.dir[`IOPCD_PORT_D] == DIR_DG) begin
      err_d = ~pin_sync[`IOPCD_PORT_D] & ~s_reg.mask_d;
    end
    chan_err = (|err_c) | (|err_d);
    err_e = ~e_sync;
    if (s_reg.qual_flag && !chan_err) begin
      err_e[`IOPCD_E_HALF-1:0] = '0;
    end
    // The upper half stays unconditional in both modes.
    diag_vec = '0;
    diag_vec[`IOPCD_DV_E_LSB +: `IOPCD_PW] = err_e;
    diag_vec[`IOPCD_DV_C_LSB +: `IOPCD_PW] = err_c;
    diag_vec[`IOPCD_DV_D_LSB +: `IOPCD_PW] = err_d;
  end

  // Unused ports drive low so they may float on the board.
  always_comb begin
    for (int p = 0; p < `IOPCD_NPORT; p++) begin
      if (cfg_map.dir[p] == DIR_OUT || cfg_map.dir[p] == DIR_UN) begin
        oe_vec[p] = `IOPCD_ALL_ON;
      end else begin
        oe_vec[p] = '0;
      end
    end
  end

  assign wb_req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
  assign hand_over = change_valid & change_ready;

  always_comb begin
    s_next = s_reg;
    s_next.ack = wb_req;
    s_next.rdata = '0;
    // Parameter register written with byte lanes.
    if (wb_req && wb_we_i && wb_adr_i == `IOPCD_PRM_OFS) begin
      if (wb_sel_i[`IOPCD_SEL_QUAL]) begin
        s_next.qual_flag = wb_dat_i[`IOPCD_PRM_QUAL_BIT];
      end
      if (wb_sel_i[`IOPCD_SEL_MC]) begin
        s_next.mask_c = wb_dat_i[`IOPCD_PRM_MC_LSB +: `IOPCD_PW];
      end
      if (wb_sel_i[`IOPCD_SEL_MD]) begin
        s_next.mask_d = wb_dat_i[`IOPCD_PRM_MD_LSB +: `IOPCD_PW];
      end
    end
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        `IOPCD_PRM_OFS: begin
          s_next.rdata[`IOPCD_PRM_QUAL_BIT] = s_reg.qual_flag;
          s_next.rdata[`IOPCD_PRM_MC_LSB +: `IOPCD_PW] = s_reg.mask_c;
          s_next.rdata[`IOPCD_PRM_MD_LSB +: `IOPCD_PW] = s_reg.mask_d;
        end
        `IOPCD_STAT_OFS: begin
          s_next.rdata[`IOPCD_ST_CODE_LSB +: `IOPCD_CW] = cfg_code;
          s_next.rdata[`IOPCD_ST_OVERALL_BIT] = cfg_map.overall;
          s_next.rdata[`IOPCD_ST_EXT_BIT] = cfg_map.ext_diag;
          s_next.rdata[`IOPCD_ST_ERR_BIT] = s_reg.diag_err;
          s_next.rdata[`IOPCD_ST_CHG_BIT] = change_valid;
          s_next.rdata[`IOPCD_ST_DIR_LSB +: `IOPCD_PW] = cfg_map.dir;
        end
        `IOPCD_NOW_OFS: begin
          s_next.rdata[`IOPCD_DW-1:0] = s_reg.cur_diag;
        end
        `IOPCD_LAST_OFS: begin
          s_next.rdata[`IOPCD_DW-1:0] = s_reg.last_diag;
        end
        default: begin
          s_next.rdata = '0;
        end
      endcase
    end
    s_next.cur_diag = diag_vec;
    s_next.diag_err = |diag_vec;
    // The snapshot follows exactly what the engine accepted, so a change
    // that lands in the hand-over cycle is offered again afterwards.
    if (hand_over) begin
      s_next.last_diag = s_reg.cur_diag;
    end
    s_next.cons_strobe = eng_cons_req & cfg_map.overall;
    for (int p = 0; p < `IOPCD_NPORT; p++) begin
      s_next.in_data[p] = (cfg_map.dir[p] == DIR_IN) ? pin_sync[p] : `IOPCD_IDLE_PORT;
      s_next.out_data[p] = (cfg_map.dir[p] == DIR_OUT) ? eng_out[p] : `IOPCD_IDLE_PORT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdata;
  assign diag_error_out = s_reg.diag_err;
  assign consistency_strobe = s_reg.cons_strobe;
  assign change_valid = (s_reg.cur_diag != s_reg.last_diag);
  assign change_data = s_reg.cur_diag;
  assign port_a_o = s_reg.out_data[0];
  assign port_b_o = s_reg.out_data[1];
  assign port_c_o = s_reg.out_data[2];
  assign port_d_o = s_reg.out_data[3];
  assign port_a_oe = oe_vec[0];
  assign port_b_oe = oe_vec[1];
  assign port_c_oe = oe_vec[2];
  assign port_d_oe = oe_vec[3];
  assign eng_in_a = s_reg.in_data[0];
  assign eng_in_b = s_reg.in_data[1];
  assign eng_in_c = s_reg.in_data[2];
  assign eng_in_d = s_reg.in_data[3];

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  decode_overall_a: assert property (
    cfg_map.overall |-> cfg_code[`IOPCD_CW-1]
  ) else $error("overall consistency decoded from a low code");

  unused_drive_a: assert property (
    cfg_map.dir[0] == DIR_UN |-> port_a_oe == `IOPCD_ALL_ON && port_a_o == '0
  ) else $error("unused port A not driven low");

  chan_diag_in_a: assert property (
    cfg_map.ext_diag |-> port_c_oe == '0 && cfg_code[`IOPCD_CW-1]
  ) else $error("channel diagnosis port C is driven");

  e_low_err_a: assert property (
    !s_reg.qual_flag && e_sync != `IOPCD_PIN_RST |=> diag_error_out
  ) else $error("port E low did not raise the error output");

  err_clear_a: assert property (
    diag_vec == '0 |=> !diag_error_out
  ) else $error("error output stayed high without an error level");

  qual_low_a: assert property (
    s_reg.qual_flag && !chan_err && e_sync[`IOPCD_PW-1:`IOPCD_E_HALF] == 4'hF
      |=> !diag_error_out
  ) else $error("low half of port E counted without channel error");

  qual_high_a: assert property (
    s_reg.qual_flag && e_sync[`IOPCD_PW-1:`IOPCD_E_HALF] != 4'hF
      |=> diag_error_out
  ) else $error("high half of port E ignored in qualified mode");

  chan_err_a: assert property (
    cfg_map.ext_diag && (~pin_sync[`IOPCD_PORT_C] & ~s_reg.mask_c) != '0
      |=> diag_error_out
  ) else $error("unmasked channel error missed");

  mask_gate_a: assert property (
    (pin_sync[`IOPCD_PORT_C] | s_reg.mask_c) == `IOPCD_ALL_ON &&
      (pin_sync[`IOPCD_PORT_D] | s_reg.mask_d) == `IOPCD_ALL_ON |-> !chan_err
  ) else $error("masked channel still forwarded");

  mask_reset_a: assert property (
    $fell(reset) |-> s_reg.mask_c == '0 && s_reg.mask_d == '0 && !s_reg.qual_flag
  ) else $error("masks not cleared by reset");

  report_once_a: assert property (
    hand_over ##1 $stable(s_reg.cur_diag) |-> !change_valid
  ) else $error("accepted change offered again");

  snapshot_a: assert property (
    hand_over |=> s_reg.last_diag == $past(s_reg.cur_diag)
  ) else $error("snapshot not taken at hand-over");

  cons_strobe_a: assert property (
    ##1 consistency_strobe == $past(eng_cons_req && cfg_map.overall)
  ) else $error("consistency strobe wrong");

  sync_depth_a: assert property (
    ##3 e_sync == $past(port_e_i, 2)
  ) else $error("port E sync depth is not two");

  wb_ack_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("bus answer not a single cycle");

  report_c: cover property (change_valid ##[1:8] hand_over);
  err_rise_c: cover property ($rose(diag_error_out));
  qual_mode_c: cover property (s_reg.qual_flag && chan_err && diag_error_out);
  cons_c: cover property (consistency_strobe);

endmodule : iopcd_top
